// *** inc/blc_pkg.sv ***
// Functional notes
// - each frame starts with the programmed dark row count, host keeps it 1..255.
// - in global shutter a dark row is 160 kernels long.
// - in rolling shutter a dark row is as long as the active window.
// - skip bit blanks the first dark row and keeps it out of calibration.
// - auto enable one computes offset from dark samples, zero disables it.
// - the computed offset is applied to every image pixel.
// - dark sample pixels leave raw and uncompensated.
// - with auto off, the nine-bit manual offset is applied to regular pixels.
// - sign zero adds the manual offset, sign one subtracts it.
// - the manual sign is ignored while auto calibration is on.
// - with auto off all data paths use the same manual offset.
// - dark samples of each path are low-pass filtered first.
// - filter sample count is two to the power of the exponent field.
// - too few samples sets that path's shortfall flag.
// - only even kernels are used as samples, half of each even-length row.
// - a flagged path is not compensated correctly; host must act.
// - automatic calibration repeats every frame.
// - calibration works on kernels of 8 adjacent columns.
// - compensated values below zero clip to zero.
package blc_pkg;
	localparam int NPATH = 4;
	localparam int PIXW  = 10;
	localparam int SUMW  = PIXW + 7;
	localparam int KERNEL_COLS = 8;

	// register addresses
	localparam logic [8:0] ADDR_FILTER_CFG = 9'h080;
	localparam logic [8:0] ADDR_OFFSET_CTL = 9'h081;
	localparam logic [8:0] ADDR_SHORT_STAT = 9'h088;
	localparam logic [8:0] ADDR_DARK_SETUP = 9'h0c5;

	// field positions
	localparam int EXP_LSB    = 8;
	localparam int AUTO_BIT   = 0;
	localparam int OFS_LSB    = 1;
	localparam int SIGN_BIT   = 10;
	localparam int ROWS_LSB   = 0;
	localparam int GATE_BIT   = 8;

	// reset values
	localparam logic [2:0] RST_EXP   = 3'h3;
	localparam logic       RST_AUTO  = 1'b1;
	localparam logic [8:0] RST_OFS   = 9'h000;
	localparam logic       RST_SIGN  = 1'b0;
	localparam logic [7:0] RST_ROWS  = 8'h08;
	localparam logic       RST_GATE  = 1'b1;

	// row length in kernels for global shutter
	localparam logic [7:0] GS_ROW_KERNELS = 8'ha0;

	typedef logic [PIXW-1:0] blc_pix_type;
	typedef logic [NPATH-1:0][PIXW-1:0] blc_pix_bus_type;

	typedef struct packed {
		logic        wr;
		logic [8:0]  addr;
		logic [15:0] wdata;
	} blc_reg_req_type;

	typedef enum logic [1:0] {
		BLC_IDLE,
		BLC_DARK,
		BLC_CALC,
		BLC_IMAGE
	} blc_state_type;
endpackage : blc_pkg

// *** logic/blc_path_filter.sv ***
`timescale 1ns/1ns
`default_nettype none
module blc_path_filter (
	// clock and reset
	input  wire logic              clk_sys_i,
	input  wire logic              rst_n_i,
	// control
	input  wire logic              clear_i,
	input  wire logic              done_i,
	input  wire logic [2:0]        exp_i,
	// samples
	input  wire logic              sample_i,
	input  wire blc_pkg::blc_pix_type data_i,
	// result
	output logic                   short_o,
	output blc_pkg::blc_pix_type   level_o
);
	import blc_pkg::*;

	logic [SUMW-1:0] sum_q, sum_d;
	logic [7:0]      cnt_q, cnt_d;
	logic            short_q, short_d;
	blc_pix_type     level_q, level_d;
	logic [7:0]      target;
	logic [SUMW-1:0] avg;

	assign target = 8'(1) << exp_i;
	assign avg    = sum_q >> exp_i;

	always_comb begin
		sum_d   = sum_q;
		cnt_d   = cnt_q;
		short_d = short_q;
		level_d = level_q;
		if (clear_i) begin
			sum_d = '0;
			cnt_d = '0;
		end else if (sample_i && cnt_q < target) begin
			sum_d = sum_q + SUMW'(data_i);
			cnt_d = cnt_q + 8'h01;
		end
		if (done_i) begin
			short_d = (cnt_q != target);
			// a short path keeps last good level rather than a biased one
			if (cnt_q == target)
				level_d = avg[PIXW-1:0];
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sum_q   <= '0;
			cnt_q   <= '0;
			short_q <= 1'b0;
			level_q <= '0;
		end else begin
			sum_q   <= sum_d;
			cnt_q   <= cnt_d;
			short_q <= short_d;
			level_q <= level_d;
		end
	end

	assign short_o = short_q;
	assign level_o = level_q;

	// exponent may shrink between frames, so only growth past the cap counts
	a_filter_cap: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n_i)
		(!clear_i && cnt_q >= target) |=> $stable(cnt_q))
		else $error("filter took more samples than requested");
endmodule : blc_path_filter
`default_nettype wire

// *** logic/blc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module blc_top (
	// clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    nrst_i,
	// register port behind the serial interface
	input  wire blc_pkg::blc_reg_req_type reg_req_i,
	output logic [15:0]                  reg_rdata_o,
	// frame control
	input  wire logic                    frame_start_i,
	input  wire logic                    frame_end_i,
	input  wire logic                    rolling_i,
	input  wire logic [7:0]              window_kernels_i,
	output logic                         dark_gen_o,
	// pixel stream from the converters
	input  wire logic [blc_pkg::NPATH-1:0] pix_valid_i,
	input  wire blc_pkg::blc_pix_bus_type  pix_i,
	// pixel stream out
	output logic [blc_pkg::NPATH-1:0]    pix_valid_o,
	output blc_pkg::blc_pix_bus_type     pix_o,
	output logic                         pix_dark_o
);
	import blc_pkg::*;

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_n;

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	logic [2:0]        exp_q, exp_d;
	logic              auto_q, auto_d;
	logic [8:0]        ofs_q, ofs_d;
	logic              sign_q, sign_d;
	logic [7:0]        rows_q, rows_d;
	logic              gate_q, gate_d;
	logic [15:0]       rdata_q, rdata_d;
	logic [NPATH-1:0]  short_flags;

	always_comb begin
		exp_d   = exp_q;
		auto_d  = auto_q;
		ofs_d   = ofs_q;
		sign_d  = sign_q;
		rows_d  = rows_q;
		gate_d  = gate_q;
		rdata_d = 16'h0000;
		if (reg_req_i.wr) begin
			case (reg_req_i.addr)
			ADDR_FILTER_CFG: exp_d = reg_req_i.wdata[EXP_LSB +: 3];
			ADDR_OFFSET_CTL: begin
				auto_d = reg_req_i.wdata[AUTO_BIT];
				ofs_d  = reg_req_i.wdata[OFS_LSB +: 9];
				sign_d = reg_req_i.wdata[SIGN_BIT];
			end
			ADDR_DARK_SETUP: begin
				rows_d = reg_req_i.wdata[ROWS_LSB +: 8];
				gate_d = reg_req_i.wdata[GATE_BIT];
			end
			default: ;
			endcase
		end else begin
			// unmapped and write-only cycles read as zero
			case (reg_req_i.addr)
			ADDR_FILTER_CFG: rdata_d[EXP_LSB +: 3] = exp_q;
			ADDR_OFFSET_CTL: begin
				rdata_d[AUTO_BIT]    = auto_q;
				rdata_d[OFS_LSB +: 9] = ofs_q;
				rdata_d[SIGN_BIT]    = sign_q;
			end
			ADDR_SHORT_STAT: rdata_d[NPATH-1:0] = short_flags;
			ADDR_DARK_SETUP: begin
				rdata_d[ROWS_LSB +: 8] = rows_q;
				rdata_d[GATE_BIT]      = gate_q;
			end
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			exp_q   <= RST_EXP;
			auto_q  <= RST_AUTO;
			ofs_q   <= RST_OFS;
			sign_q  <= RST_SIGN;
			rows_q  <= RST_ROWS;
			gate_q  <= RST_GATE;
			rdata_q <= 16'h0000;
		end else begin
			exp_q   <= exp_d;
			auto_q  <= auto_d;
			ofs_q   <= ofs_d;
			sign_q  <= sign_d;
			rows_q  <= rows_d;
			gate_q  <= gate_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata_o = rdata_q;

	// ------------------------------------------------------------
	// dark row sequencer
	// ------------------------------------------------------------
	blc_state_type state_q, state_d;
	logic [7:0]    row_q, row_d;
	logic [7:0]    kern_q, kern_d;
	logic [7:0]    nrows_q, nrows_d;
	logic          fgate_q, fgate_d;
	logic [7:0]    row_len;
	logic          row_last;
	logic          blank_row;
	logic          clear;
	logic          done;

	// row length follows the live window in rolling mode
	assign row_len   = rolling_i ? window_kernels_i
		: GS_ROW_KERNELS;
	assign row_last  = (kern_q >= row_len - 8'h01);
	assign blank_row = fgate_q && (row_q == 8'h00);
	// a refused start must not wipe samples of the running frame
	assign clear     = frame_start_i
		&& (state_q == BLC_IDLE || state_q == BLC_IMAGE);
	assign done      = (state_q == BLC_CALC);

	always_comb begin
		state_d = state_q;
		row_d   = row_q;
		kern_d  = kern_q;
		nrows_d = nrows_q;
		fgate_d = fgate_q;
		case (state_q)
		BLC_IDLE, BLC_IMAGE: begin
			if (frame_start_i) begin
				// dark row count and skip bit are sampled once per frame
				nrows_d = rows_q;
				fgate_d = gate_q;
				row_d   = 8'h00;
				kern_d  = 8'h00;
				state_d = (rows_q == 8'h00) ? BLC_CALC
					: BLC_DARK;
			end else if (frame_end_i)
				state_d = BLC_IDLE;
		end
		BLC_DARK: begin
			if (row_last) begin
				kern_d = 8'h00;
				row_d  = row_q + 8'h01;
				if (row_q == nrows_q - 8'h01)
					state_d = BLC_CALC;
			end else
				kern_d = kern_q + 8'h01;
		end
		BLC_CALC: state_d = BLC_IMAGE;
		default: state_d = BLC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= BLC_IDLE;
			row_q   <= 8'h00;
			kern_q  <= 8'h00;
			nrows_q <= 8'h00;
			fgate_q <= 1'b0;
		end else begin
			state_q <= state_d;
			row_q   <= row_d;
			kern_q  <= kern_d;
			nrows_q <= nrows_d;
			fgate_q <= fgate_d;
		end
	end

	assign dark_gen_o = (state_q == BLC_DARK);

	// ------------------------------------------------------------
	// per path filter and compensation
	// ------------------------------------------------------------
	logic [NPATH-1:0]  sample_en;
	logic [NPATH-1:0]  pvld_q, pvld_d;
	blc_pix_bus_type   pout_q, pout_d;
	blc_pix_bus_type   level;
	logic              dark_q, dark_d;

	genvar p;
	generate
		for (p = 0; p < NPATH; p++) begin : g_path
			logic [PIXW+1:0] sum;
			// each kernel carries 8 columns; only even kernels are
			// sampled, halving the usable count per row
			assign sample_en[p] = dark_gen_o && !blank_row
				&& !kern_q[0] && pix_valid_i[p];

			blc_path_filter u_filter (
				.clk_sys_i (clk_sys_i),
				.rst_n_i   (rst_n),
				.clear_i   (clear),
				.done_i    (done),
				.exp_i     (exp_q),
				.sample_i  (sample_en[p]),
				.data_i    (pix_i[p]),
				.short_o   (short_flags[p]),
				.level_o   (level[p])
			);

			always_comb begin
				sum = {2'b00, pix_i[p]};
				if (auto_q)
					sum = {2'b00, pix_i[p]}
						- {2'b00, level[p]};
				else if (sign_q)
					sum = {2'b00, pix_i[p]}
						- {3'b000, ofs_q};
				else
					sum = {2'b00, pix_i[p]} + {3'b000, ofs_q};
				pvld_d[p] = pix_valid_i[p] && (state_q == BLC_IMAGE
					|| (dark_gen_o && !blank_row));
				if (dark_gen_o)
					pout_d[p] = pix_i[p];
				else if (sum[PIXW+1])
					pout_d[p] = '0;
				else if (sum[PIXW])
					pout_d[p] = '1;
				else
					pout_d[p] = sum[PIXW-1:0];
			end
		end
	endgenerate

	assign dark_d = dark_gen_o;

	always_ff @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			pvld_q <= '0;
			pout_q <= '0;
			dark_q <= 1'b0;
		end else begin
			pvld_q <= pvld_d;
			pout_q <= pout_d;
			dark_q <= dark_d;
		end
	end

	assign pix_valid_o = pvld_q;
	assign pix_o       = pout_q;
	assign pix_dark_o  = dark_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_dark_row_end: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_DARK && row_last && row_q == nrows_q - 8'h01)
		|=> state_q == BLC_CALC)
		else $error("dark phase did not end after programmed rows");

	a_dark_hold: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_DARK && !row_last) |=> state_q == BLC_DARK)
		else $error("dark phase cut short inside a row");

	a_frame_restart: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		((state_q == BLC_IDLE || state_q == BLC_IMAGE) && frame_start_i
		&& rows_q != 8'h00)
		|=> state_q == BLC_DARK && row_q == 8'h00 && kern_q == 8'h00)
		else $error("frame start did not restart dark rows");

	a_gs_row_len: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_DARK && !rolling_i
		&& kern_q == GS_ROW_KERNELS - 8'h01)
		|=> kern_q == 8'h00)
		else $error("global shutter dark row not 160 kernels");

	a_rs_row_len: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_DARK && rolling_i && $stable(window_kernels_i)
		&& window_kernels_i != 8'h00) |-> kern_q < window_kernels_i)
		else $error("rolling dark row longer than window");

	a_first_gated: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(dark_gen_o && fgate_q && row_q == 8'h00)
		|=> pix_valid_o == '0)
		else $error("first dark row not blanked");

	a_dark_is_raw: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(dark_gen_o && !blank_row && pix_valid_i[0])
		|=> pix_valid_o[0] && pix_o[0] == $past(pix_i[0]))
		else $error("dark sample was altered");

	a_auto_sub: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && auto_q && pix_i[2] >= level[2])
		|=> pix_o[2] == $past(pix_i[2] - level[2]))
		else $error("automatic offset not applied");

	a_sign_ignored: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && auto_q && sign_q
		&& pix_i[1] >= level[1])
		|=> pix_o[1] == $past(pix_i[1] - level[1]))
		else $error("manual sign used in automatic mode");

	a_clip_zero: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && auto_q && pix_i[1] < level[1])
		|=> pix_o[1] == '0)
		else $error("negative result not clipped");

	a_manual_sub: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && !auto_q && sign_q
		&& {1'b0, pix_i[0]} >= {2'b00, ofs_q})
		|=> pix_o[0] == $past(pix_i[0] - PIXW'(ofs_q)))
		else $error("manual subtract wrong");

	a_manual_same: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && !auto_q && pix_i[0] == pix_i[3])
		|=> pix_o[0] == pix_o[3])
		else $error("paths used different manual offsets");

	a_half_kernels: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		sample_en[2] |-> !kern_q[0] && !blank_row)
		else $error("odd kernel or blanked row sampled");

	a_flags_renew: assert property (
		@(posedge clk_sys_i) disable iff (!rst_n)
		(state_q == BLC_IMAGE && !frame_start_i) |=> $stable(short_flags))
		else $error("shortfall flags changed outside calibration");
endmodule : blc_top
`default_nettype wire

// *** verification/blc_pixel_source.sv ***
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// converter side: dark and image samples
// ----------------------------------------
module blc_pixel_source (
	// clock
	input  wire logic                       clk_sys_i,
	// control from device and bench
	input  wire logic                       dark_gen_i,
	input  wire logic                       img_valid_i,
	input  wire logic [9:0]                 img_i,
	input  wire logic [9:0]                 dark_i,
	// samples to the device
	output logic [blc_pkg::NPATH-1:0]       pix_valid_o,
	output blc_pkg::blc_pix_bus_type        pix_o
);
	import blc_pkg::*;
	blc_pix_bus_type last_q = '0;
	always_comb begin
		for (int p = 0; p < NPATH; p++) begin
			// a dark sample on every dark cycle, offset per path
			pix_valid_o[p] = dark_gen_i | img_valid_i;
			// idle lines toggle so a stale value never passes
			pix_o[p] = dark_gen_i ? dark_i + 10'(p) :
				img_valid_i ? img_i : ~last_q[p];
		end
	end
	always_ff @(posedge clk_sys_i) last_q <= pix_o;
endmodule : blc_pixel_source
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import blc_pkg::*;
	logic            clk_sys_i, nrst_i = 0, start = 0, rolling = 0, fend = 0;
	logic            img_v = 0, dark_gen, pdark, sgn = 0, auto_on = 1;
	logic [7:0]      win = 8'h04;
	logic [9:0]      img = 0, dark = 0;
	logic [15:0]     rdata;
	logic [3:0]      pv_i, pv_o;
	blc_reg_req_type req = '0;
	blc_pix_bus_type px_i, px_o;
	int              fails = 0, comparisons = 0, cyc = 0, lvl = 0, ofs = 0;

	blc_top blc_top_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.reg_req_i(req), .reg_rdata_o(rdata), .frame_start_i(start),
		.frame_end_i(fend), .rolling_i(rolling), .window_kernels_i(win),
		.dark_gen_o(dark_gen), .pix_valid_i(pv_i), .pix_i(px_i),
		.pix_valid_o(pv_o), .pix_o(px_o), .pix_dark_o(pdark));
	blc_pixel_source blc_pixel_source_inst (.clk_sys_i(clk_sys_i),
		.dark_gen_i(dark_gen), .img_valid_i(img_v), .img_i(img),
		.dark_i(dark), .pix_valid_o(pv_i), .pix_o(px_i));

	initial begin
		clk_sys_i = 0;
		forever #4 clk_sys_i = ~clk_sys_i;
	end

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] want);
		comparisons++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, want);
		end
	endtask : chk

	task wr(input logic [8:0] a, input logic [15:0] d);
		@(posedge clk_sys_i) req <= '{1'b1, a, d};
		@(posedge clk_sys_i) req.wr <= 1'b0;
	endtask : wr

	task rd(input logic [8:0] a, input logic [15:0] want);
		@(posedge clk_sys_i) req <= '{1'b0, a, 16'h0000};
		@(posedge clk_sys_i);
		#1 chk(rdata, want);
	endtask : rd

	// one image pixel on all paths; expectation from the level in use
	task px(input int v);
		int e;
		@(posedge clk_sys_i) begin
			img_v <= 1'b1;
			img <= 10'(v);
		end
		@(posedge clk_sys_i) img_v <= 1'b0;
		#1;
		for (int p = 0; p < NPATH; p++) begin
			e = auto_on ? v - lvl - p : sgn ? v - ofs : v + ofs;
			e = e < 0 ? 0 : e > 1023 ? 1023 : e;
			chk({pdark, pv_o[p], 4'h0, px_o[p]}, {2'b01, 4'h0, 10'(e)});
		end
	endtask : px

	// start a frame, count dark cycles and raw dark outputs
	task frame(input int nd, input int nk, input logic [15:0] fl);
		int d, k;
		logic [9:0] raw;
		d = 0;
		k = 0;
		raw = 0;
		@(posedge clk_sys_i) start <= 1'b1;
		@(posedge clk_sys_i) start <= 1'b0;
		repeat (3000) begin
			#1;
			d += int'(dark_gen);
			if (pv_o[1] & pdark) begin
				k++;
				raw = px_o[1];
			end
			if (d > 0 && !dark_gen) break;
			@(posedge clk_sys_i);
		end
		chk(16'(d), 16'(nd));
		chk(16'(k), 16'(nk));
		chk(16'(raw), 16'(dark + 10'h001));
		rd(ADDR_SHORT_STAT, fl);
	endtask : frame

	task done(input string name);
		$display("test %s done", name);
	endtask : done

	task stop_test();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// a hang is cut short well past the expected run length
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			stop_test();
		end
	end

	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		rd(ADDR_FILTER_CFG, 16'h0300);
		rd(ADDR_OFFSET_CTL, 16'h0001);
		rd(ADDR_DARK_SETUP, 16'h0108);
		wr(ADDR_SHORT_STAT, 16'hffff);
		rd(ADDR_SHORT_STAT, 16'h0000);
		rd(9'h1ff, 16'h0000);
		done("registers");
		wr(ADDR_DARK_SETUP, 16'h0001);
		dark = 10'd20;
		lvl = 20;
		frame(160, 160, 16'h0000);
		px(100);
		px(15);
		done("global");
		@(posedge clk_sys_i) rolling <= 1'b1;
		wr(ADDR_DARK_SETUP, 16'h0102);
		wr(ADDR_FILTER_CFG, 16'h0100);
		wr(ADDR_OFFSET_CTL, 16'h07ff);
		dark = 10'd40;
		lvl = 40;
		frame(8, 4, 16'h0000);
		px(100);
		done("rolling");
		wr(ADDR_FILTER_CFG, 16'h0200);
		dark = 10'd10;
		frame(8, 4, 16'h000f);
		px(100);
		wr(ADDR_FILTER_CFG, 16'h0100);
		dark = 10'd25;
		lvl = 25;
		frame(8, 4, 16'h0000);
		px(100);
		done("shortfall");
		wr(ADDR_OFFSET_CTL, 16'h003c);
		auto_on = 1'b0;
		ofs = 30;
		frame(8, 4, 16'h0000);
		px(1000);
		px(100);
		wr(ADDR_OFFSET_CTL, 16'h043c);
		sgn = 1'b1;
		frame(8, 4, 16'h0000);
		px(100);
		px(10);
		// after frame end an image pixel must not come out
		@(posedge clk_sys_i) fend <= 1'b1;
		@(posedge clk_sys_i) begin
			fend <= 1'b0;
			img_v <= 1'b1;
		end
		@(posedge clk_sys_i) img_v <= 1'b0;
		#1 chk(16'(pv_o), 16'h0000);
		done("manual");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
